// ---- dv/ddrseq_mem_model.sv ----
// Behavioural DDR SDRAM device that counts every break of its command rules.
// Assumes commands are sampled on the rising edge of the shared clock.
`timescale 1ns/1ps
module ddrseq_mem_model
	import ddrseq_pkg::*;
#(
	parameter int PU = 20,
	parameter int GAP = 40
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Command pins
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BA_W-1:0] ba,
	input wire logic [ADDR_W-1:0] addr,
	// Settings the host was told to load
	input wire logic [ADDR_W-1:0] exp_mode,
	input wire logic exp_drive,
	// Observations
	output int errs,
	output int step,
	output int n_ref,
	output int age
);
	logic [3:0] cmd;
	logic [ADDR_W-1:0] dll_on;
	logic ok;
	int pw;
	int gap;
	int need;
	int since;
	int up;
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign dll_on = exp_mode | (13'h1 << MODE_DLL_RESET_BIT);
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			errs = 0;
			step = 0;
			n_ref = 0;
			age = 0;
			pw = 0;
			gap = 0;
			need = 0;
			since = 0;
			up = 0;
		end
		else
		begin
			gap++;
			age++;
			since++;
			ok = 1'b1;
			if (cke !== 1'b1)
			begin
				pw++;
				// Clock enable may never drop once raised.
				if (up != 0 || (cs_n === 1'b0 && cmd !== CMD_NOP)) ok = 1'b0;
			end
			else if (up == 0)
			begin
				if (pw < PU) ok = 1'b0;
				up = 1;
			end
			if (cke === 1'b1 && cs_n === 1'b0 && cmd !== CMD_NOP)
			begin
				if (up == 1 || gap < need) ok = 1'b0;
				gap = 0;
				case (cmd)
					CMD_PRECHARGE: need = PRECHARGE_CYC;
					CMD_LOAD_MODE: need = MODE_LOAD_CYC;
					CMD_REFRESH: need = REFRESH_CYC;
					default: need = 0;
				endcase
				if (cmd === CMD_LOAD_MODE && ba === BA_BASE_MODE
					&& addr[MODE_DLL_RESET_BIT] === 1'b1)
					age = 0;
				case (step)
					0, 3: ok &= cmd === CMD_PRECHARGE && addr[ALL_BANKS_BIT];
					1: ok &= cmd === CMD_LOAD_MODE && ba === BA_EXT_MODE
						&& addr === {11'h0, exp_drive, 1'b0};
					2: ok &= cmd === CMD_LOAD_MODE && ba === BA_BASE_MODE
						&& addr === dll_on;
					4, 5: ok &= cmd === CMD_REFRESH;
					6: ok &= cmd !== CMD_LOAD_MODE || addr === exp_mode
						|| addr === dll_on;
					default: ok &= 1'b1;
				endcase
				if (step < 6 || (step == 6 && cmd === CMD_LOAD_MODE
					&& addr === exp_mode))
					step++;
				if (cmd === CMD_REFRESH)
				begin
					n_ref++;
					since = 0;
				end
			end
			if (cke === 1'b1 && up == 1) up = 2;
			if (step >= 6 && since > GAP) ok = 1'b0;
			if (!ok) errs++;
		end
	end
endmodule

// ---- dv/ddrseq_top_tb.sv ----
// Self-checking bench for the DDR power-up and refresh sequencer.
// Assumes the package, the design and the memory model compile first.
`timescale 1ns/1ps
module ddrseq_top_tb import ddrseq_pkg::*;;
	localparam int PU = 20;
	localparam int GAP = 40;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cke, cs_n, ras_n, cas_n, we_n;
	logic [BA_W-1:0] ba;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] exp_mode = 13'h0;
	logic drive = 1'b0;
	logic [31:0] rd;
	logic er;
	int errs, step, n_ref, age;
	int n_errors = 0;
	int n_tests = 0;
	always #5 clk = ~clk;
	ddrseq_top #(.POWERUP_CYCLES(PU), .REFRESH_GAP_CYCLES(GAP)) u_ddrseq_top (
		.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mem_cke(cke), .mem_cs_n(cs_n),
		.mem_ras_n(ras_n), .mem_cas_n(cas_n), .mem_we_n(we_n),
		.mem_ba(ba), .mem_addr(addr));
	ddrseq_mem_model #(.PU(PU), .GAP(GAP)) u_ddrseq_mem_model (
		.clk(clk), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
		.exp_mode(exp_mode), .exp_drive(drive), .errs(errs), .step(step),
		.n_ref(n_ref), .age(age));
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// The request stands until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [31:0] stx();
		return {29'h0, 1'b0, age >= int'(DLL_LOCK_CYCLES), 1'b1};
	endfunction
	// Status reads follow a refresh by its cycle time, clear of the busy
	// window, so a relock order also lands while the sequencer is ready.
	task automatic after_ref();
		int n1;
		n1 = n_ref;
		wait (n_ref != n1);
		repeat (REFRESH_CYC) @(posedge clk);
	endtask
	task automatic final_report();
		if (n_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		logic [31:0] cw;
		int n0;
		int k;
		void'($urandom(32'hf4f4));
		// The second pass also resets the design in mid-run.
		for (int p = 0; p < 2; p++)
		begin
			resetn <= 1'b0;
			repeat (6) @(posedge clk);
			resetn <= 1'b1;
			apb(1'b0, REG_CTRL, 32'h0);
			chk("ctrl", 32'h0, rd);
			apb(1'b0, REG_MODE, 32'h0);
			chk("mode", 32'(MODE_RESET_VAL), rd);
			apb(1'b0, REG_STATUS, 32'h0);
			chk("status", 32'h0, rd);
			apb(1'b1, 8'h0c, 32'hffffffff);
			chk("slverr", 32'h1, 32'(er));
			apb(1'b0, 8'h0c, 32'h0);
			chk("unmapped", 32'h0, rd);
			exp_mode = 13'($urandom) & 13'h1eff;
			drive = 1'($urandom);
			apb(1'b1, REG_MODE, 32'(exp_mode));
			apb(1'b0, REG_MODE, 32'h0);
			chk("mode_rb", 32'(exp_mode), rd);
			cw = 32'h8 | (32'(drive) << 1) | (32'(p == 0) << 2);
			apb(1'b1, REG_CTRL, cw | 32'h1);
			// A second start while busy must not restart the sequence.
			apb(1'b1, REG_CTRL, cw | 32'h1);
			k = 0;
			do
			begin
				apb(1'b0, REG_STATUS, 32'h0);
				k++;
			end
			while (rd[ST_DONE] !== 1'b1 && k < 200);
			chk("done", stx(), rd);
			chk("step", (p == 0) ? 32'd7 : 32'd6, 32'(step));
			n0 = n_ref;
			repeat (240) @(posedge clk);
			chk("refresh", 32'h1, 32'(n_ref - n0 >= 240 / (GAP + 1)));
			after_ref();
			apb(1'b0, REG_STATUS, 32'h0);
			chk("locked", stx(), rd);
			apb(1'b1, REG_CTRL, cw | 32'h10);
			repeat (30) @(posedge clk);
			chk("relock", 32'h1, 32'(age < 40));
			apb(1'b0, REG_STATUS, 32'h0);
			chk("unlocked", stx(), rd);
			chk("model", 32'h0, 32'(errs));
		end
		final_report();
	end
	initial
	begin
		#60000;
		n_errors++;
		final_report();
	end
endmodule

// ---- logic/ddrseq_apb_if.sv ----
// Interface between the sequencer core and its APB register slave.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface ddrseq_apb_if;
	import ddrseq_pkg::*;
	logic [ADDR_W-1:0] ctrl;
	logic [ADDR_W-1:0] mode;
	logic start_pulse;
	logic relock_pulse;
	logic [2:0] status;
	modport regs (output ctrl, output mode, output start_pulse,
		output relock_pulse, input status);
	modport core (input ctrl, input mode, input start_pulse,
		input relock_pulse, output status);
endinterface

// ---- logic/ddrseq_apb_regs.sv ----
// APB slave holding control, mode-word and status registers.
// Assumes an APB master on clk; answers every access with zero wait.
`timescale 1ns/1ps
module ddrseq_apb_regs
	import ddrseq_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core side
	ddrseq_apb_if.regs bus
);
	typedef struct packed {
		logic [ADDR_W-1:0] ctrl;
		logic [ADDR_W-1:0] mode;
		logic start_pulse;
		logic relock_pulse;
		logic [31:0] prdata;
		logic pslverr;
	} ddrseq_regs_s;
	ddrseq_regs_s r;
	ddrseq_regs_s next_r;
	logic acc;
	assign acc = psel && penable;
	always_comb
	begin
		next_r = r;
		next_r.start_pulse = 1'b0;
		next_r.relock_pulse = 1'b0;
		if (psel && !penable)
		begin
			next_r.pslverr = !(paddr == REG_CTRL || paddr == REG_MODE ||
				paddr == REG_STATUS);
			unique case (paddr)
				REG_CTRL: next_r.prdata = {19'h0, r.ctrl};
				REG_MODE: next_r.prdata = {19'h0, r.mode};
				REG_STATUS: next_r.prdata = {29'h0, bus.status};
				default: next_r.prdata = 32'h0;
			endcase
		end
		if (acc && pwrite)
		begin
			if (paddr == REG_CTRL)
			begin
				next_r.ctrl = pwdata[ADDR_W-1:0];
				next_r.start_pulse = pwdata[CTRL_START];
				next_r.relock_pulse = pwdata[CTRL_DLL_RELOCK];
			end
			if (paddr == REG_MODE)
				next_r.mode = pwdata[ADDR_W-1:0];
		end
		if (!resetn)
		begin
			next_r = '0;
			next_r.mode = MODE_RESET_VAL;
		end
	end
	always_ff @(posedge clk)
		r <= next_r;
	assign prdata = r.prdata;
	assign pslverr = r.pslverr;
	assign pready = 1'b1;
	assign bus.ctrl = r.ctrl;
	assign bus.mode = r.mode;
	assign bus.start_pulse = r.start_pulse;
	assign bus.relock_pulse = r.relock_pulse;
endmodule

// ---- logic/ddrseq_pkg.sv ----
// Package for the DDR SDRAM init and refresh sequencer (host side).
// Assumes a 100 MHz system clock and an APB register port.
package ddrseq_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Timing figures in their own units.
	localparam int unsigned POWERUP_WAIT_US = 200;
	localparam int unsigned PRECHARGE_PERIOD_NS = 15;
	localparam int unsigned MODE_LOAD_DELAY_NS = 12;
	localparam int unsigned REFRESH_CYCLE_TIME_NS = 75;
	localparam int unsigned REFRESH_MAX_GAP_NS = 70300;
	localparam int unsigned DLL_LOCK_CYCLES = 200;
	localparam int unsigned MAX_POSTED_REFRESH = 8;
	// Derived cycle counts; least times round up.
	localparam int unsigned POWERUP_CYC =
		(POWERUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PRECHARGE_CYC =
		(PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned MODE_LOAD_CYC =
		(MODE_LOAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned REFRESH_CYC =
		(REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Longest time rounds down.
	localparam int unsigned REFRESH_GAP_CYC =
		REFRESH_MAX_GAP_NS / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 16;
	// Command encodings as {cs_n, ras_n, cas_n, we_n}.
	localparam logic [3:0] CMD_DESELECT = 4'h8;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
	localparam int unsigned ADDR_W = 13;
	localparam int unsigned BA_W = 2;
	localparam int unsigned ALL_BANKS_BIT = 10;
	localparam int unsigned EXT_DLL_DISABLE_BIT = 0;
	localparam int unsigned EXT_DRIVE_STRENGTH_BIT = 1;
	localparam int unsigned MODE_DLL_RESET_BIT = 8;
	localparam logic [1:0] BA_BASE_MODE = 2'h0;
	localparam logic [1:0] BA_EXT_MODE = 2'h1;
	// APB register offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MODE = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_REDUCED_DRIVE = 1;
	localparam int unsigned CTRL_DLL_CLEAR = 2;
	localparam int unsigned CTRL_REFRESH_EN = 3;
	localparam int unsigned CTRL_DLL_RELOCK = 4;
	localparam int unsigned ST_DONE = 0;
	localparam int unsigned ST_DLL_LOCKED = 1;
	localparam int unsigned ST_BUSY = 2;
	localparam logic [ADDR_W-1:0] MODE_RESET_VAL = 13'h0032;
	typedef enum logic [4:0] {
		DDRSEQ_IDLE, DDRSEQ_POWERUP, DDRSEQ_NOP1, DDRSEQ_PRE1,
		DDRSEQ_PRE1_WAIT, DDRSEQ_EMR, DDRSEQ_EMR_WAIT, DDRSEQ_MR,
		DDRSEQ_MR_WAIT, DDRSEQ_PRE2, DDRSEQ_PRE2_WAIT, DDRSEQ_REF1,
		DDRSEQ_REF1_WAIT, DDRSEQ_REF2, DDRSEQ_REF2_WAIT, DDRSEQ_MR2,
		DDRSEQ_MR2_WAIT, DDRSEQ_READY, DDRSEQ_AREF, DDRSEQ_AREF_WAIT,
		DDRSEQ_RELOCK, DDRSEQ_RELOCK_WAIT
	} ddrseq_state_e;
endpackage

// ---- logic/ddrseq_top.sv ----
// Host-side DDR SDRAM power-up and refresh sequencer with APB control.
// Assumes the memory is clocked from clk and commands are sampled on it.
// Behaviour
// - Never let more than eight refreshes become overdue or posted.
// - Issue auto refresh at gaps no longer than 70.3 us.
// - Keep clock enable high from refresh until its cycle time ends.
// - Auto-precharge accesses only once row active time is met.
// - After clock change reset the DLL, then wait 200 cycles.
// - At power-up hold clock enable low, wait at least 200 us.
// - Raise clock enable and give a no-operation before other commands.
// - Precharge all, then wait precharge period with idle commands.
// - Precharge period is at least 15 ns.
// - Extended mode load enables DLL, sets drive strength, rest zero.
// - After each mode load wait mode-load delay with idle commands.
// - Base mode load with DLL reset; 200 cycles before any read.
// - Second precharge all, then wait the precharge period idle.
// - Two auto refreshes, each followed by refresh cycle time idle.
// - Optionally reload base mode with DLL reset bit cleared.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module ddrseq_top
	import ddrseq_pkg::*;
#(
	parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
	parameter int unsigned REFRESH_GAP_CYCLES = REFRESH_GAP_CYC
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Memory command pins
	output logic mem_cke,
	output logic mem_cs_n,
	output logic mem_ras_n,
	output logic mem_cas_n,
	output logic mem_we_n,
	output logic [BA_W-1:0] mem_ba,
	output logic [ADDR_W-1:0] mem_addr
);
	localparam logic [CNT_W-1:0] PRE_CNT = CNT_W'(PRECHARGE_CYC);
	localparam logic [CNT_W-1:0] MRD_CNT = CNT_W'(MODE_LOAD_CYC);
	localparam logic [CNT_W-1:0] RFC_CNT = CNT_W'(REFRESH_CYC);
	localparam logic [CNT_W-1:0] DLL_CNT = CNT_W'(DLL_LOCK_CYCLES);
	localparam logic [CNT_W-1:0] PWR_CNT = CNT_W'(POWERUP_CYCLES);
	localparam logic [CNT_W-1:0] GAP_CNT = CNT_W'(REFRESH_GAP_CYCLES);
	localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
	// Latest cycle at which the lock flag may rise after a DLL reset load.
	localparam int DLL_WAIT_MAX = DLL_LOCK_CYCLES + 2;

	typedef struct packed {
		ddrseq_state_e state;
		logic [CNT_W-1:0] wait_cnt;
		logic [CNT_W-1:0] gap_cnt;
		logic [CNT_W-1:0] dll_cnt;
		logic dll_locked;
		logic done;
		logic cke;
		logic [3:0] cmd;
		logic [BA_W-1:0] ba;
		logic [ADDR_W-1:0] addr;
	} ddrseq_core_s;
	ddrseq_core_s s;
	ddrseq_core_s next_s;
	ddrseq_apb_if rif();

	ddrseq_apb_regs u_regs (
		.clk(clk),
		.resetn(resetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.bus(rif.regs)
	);

	logic wait_over;
	assign wait_over = (s.wait_cnt <= ONE);
	assign rif.status = {s.state != DDRSEQ_READY && s.state != DDRSEQ_IDLE,
		s.dll_locked, s.done};

	// Issues a command for one cycle and loads the wait that follows it.
	function automatic ddrseq_core_s issue(input ddrseq_core_s c,
		input logic [3:0] cmd, input logic [BA_W-1:0] ba,
		input logic [ADDR_W-1:0] addr, input logic [CNT_W-1:0] wt,
		input ddrseq_state_e nxt);
		ddrseq_core_s o;
		o = c;
		o.cmd = cmd;
		o.ba = ba;
		o.addr = addr;
		o.wait_cnt = wt;
		o.state = nxt;
		return o;
	endfunction

	always_comb
	begin
		logic [ADDR_W-1:0] ext_word;
		logic [ADDR_W-1:0] mode_word;
		ext_word = '0;
		ext_word[EXT_DLL_DISABLE_BIT] = 1'b0;
		ext_word[EXT_DRIVE_STRENGTH_BIT] = rif.ctrl[CTRL_REDUCED_DRIVE];
		mode_word = rif.mode;
		next_s = s;
		next_s.cmd = CMD_NOP;
		next_s.ba = '0;
		next_s.addr = '0;
		if (s.wait_cnt != '0)
			next_s.wait_cnt = s.wait_cnt - ONE;
		// The DLL lock counter runs apart from the state walk.
		// The flag rises only as a count ends, so it reads low out of reset.
		if (s.dll_cnt != '0)
		begin
			next_s.dll_cnt = s.dll_cnt - ONE;
			if (s.dll_cnt == ONE)
				next_s.dll_locked = 1'b1;
		end
		// The gap runs from the last refresh, the init ones included, so the
		// first periodic refresh is not late.
		if (s.gap_cnt != '0)
			next_s.gap_cnt = s.gap_cnt - ONE;
		unique case (s.state)
			DDRSEQ_IDLE:
				if (rif.start_pulse)
				begin
					next_s.state = DDRSEQ_POWERUP;
					next_s.wait_cnt = PWR_CNT;
					next_s.cke = 1'b0;
				end
			DDRSEQ_POWERUP:
				if (wait_over)
				begin
					next_s.cke = 1'b1;
					next_s.state = DDRSEQ_NOP1;
				end
			DDRSEQ_NOP1:
				next_s.state = DDRSEQ_PRE1;
			DDRSEQ_PRE1:
				next_s = issue(next_s, CMD_PRECHARGE, '0,
					ADDR_W'(1) << ALL_BANKS_BIT, PRE_CNT,
					DDRSEQ_PRE1_WAIT);
			DDRSEQ_PRE1_WAIT:
				if (wait_over)
					next_s.state = DDRSEQ_EMR;
			DDRSEQ_EMR:
				next_s = issue(next_s, CMD_LOAD_MODE, BA_EXT_MODE, ext_word,
					MRD_CNT, DDRSEQ_EMR_WAIT);
			DDRSEQ_EMR_WAIT:
				if (wait_over)
					next_s.state = DDRSEQ_MR;
			DDRSEQ_MR:
			begin
				mode_word[MODE_DLL_RESET_BIT] = 1'b1;
				next_s = issue(next_s, CMD_LOAD_MODE, BA_BASE_MODE, mode_word,
					MRD_CNT, DDRSEQ_MR_WAIT);
				next_s.dll_cnt = DLL_CNT;
				next_s.dll_locked = 1'b0;
			end
			DDRSEQ_MR_WAIT:
				if (wait_over)
					next_s.state = DDRSEQ_PRE2;
			DDRSEQ_PRE2:
				next_s = issue(next_s, CMD_PRECHARGE, '0,
					ADDR_W'(1) << ALL_BANKS_BIT, PRE_CNT,
					DDRSEQ_PRE2_WAIT);
			DDRSEQ_PRE2_WAIT:
				if (wait_over)
					next_s.state = DDRSEQ_REF1;
			DDRSEQ_REF1:
				next_s = issue(next_s, CMD_REFRESH, '0, '0, RFC_CNT,
					DDRSEQ_REF1_WAIT);
			DDRSEQ_REF1_WAIT:
				if (wait_over)
					next_s.state = DDRSEQ_REF2;
			DDRSEQ_REF2:
			begin
				next_s = issue(next_s, CMD_REFRESH, '0, '0, RFC_CNT,
					DDRSEQ_REF2_WAIT);
				next_s.gap_cnt = GAP_CNT;
			end
			DDRSEQ_REF2_WAIT:
				if (wait_over)
					next_s.state = rif.ctrl[CTRL_DLL_CLEAR] ? DDRSEQ_MR2 :
						DDRSEQ_READY;
			DDRSEQ_MR2:
			begin
				mode_word[MODE_DLL_RESET_BIT] = 1'b0;
				next_s = issue(next_s, CMD_LOAD_MODE, BA_BASE_MODE, mode_word,
					MRD_CNT, DDRSEQ_MR2_WAIT);
			end
			DDRSEQ_MR2_WAIT:
				if (wait_over)
					next_s.state = DDRSEQ_READY;
			DDRSEQ_READY:
			begin
				next_s.done = 1'b1;
				if (rif.relock_pulse)
					next_s.state = DDRSEQ_RELOCK;
				else if (s.done && rif.ctrl[CTRL_REFRESH_EN] &&
					s.gap_cnt <= RFC_CNT)
					next_s.state = DDRSEQ_AREF;
			end
			DDRSEQ_AREF:
			begin
				// Refreshing one at a time leaves none posted at all.
				next_s = issue(next_s, CMD_REFRESH, '0, '0, RFC_CNT,
					DDRSEQ_AREF_WAIT);
				next_s.gap_cnt = GAP_CNT;
			end
			DDRSEQ_AREF_WAIT:
				if (wait_over)
					next_s.state = DDRSEQ_READY;
			DDRSEQ_RELOCK:
			begin
				mode_word[MODE_DLL_RESET_BIT] = 1'b1;
				next_s = issue(next_s, CMD_LOAD_MODE, BA_BASE_MODE, mode_word,
					MRD_CNT, DDRSEQ_RELOCK_WAIT);
				next_s.dll_cnt = DLL_CNT;
				next_s.dll_locked = 1'b0;
			end
			DDRSEQ_RELOCK_WAIT:
				if (wait_over)
					next_s.state = DDRSEQ_READY;
			default:
				next_s.state = DDRSEQ_IDLE;
		endcase
		if (!resetn)
		begin
			next_s = '0;
			next_s.state = DDRSEQ_IDLE;
			next_s.cmd = CMD_NOP;
		end
	end

	always_ff @(posedge clk)
		s <= next_s;

	// No reads are issued by this block, so put nothing here.
	assign mem_cke = s.cke;
	assign {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = s.cmd;
	assign mem_ba = s.ba;
	assign mem_addr = s.addr;

	logic is_ref;
	logic is_pre;
	assign is_ref = (s.cmd == CMD_REFRESH);
	assign is_pre = (s.cmd == CMD_PRECHARGE);

	a_refresh_cke_high: assert property (@(posedge clk) disable iff (!resetn)
		is_ref |-> mem_cke [*8])
		else $error("clock enable fell during refresh cycle");
	a_precharge_idle: assert property (@(posedge clk) disable iff (!resetn)
		is_pre |=> (s.cmd == CMD_NOP) [*2])
		else $error("command issued inside precharge period");
	a_refresh_idle: assert property (@(posedge clk) disable iff (!resetn)
		is_ref |=> (s.cmd == CMD_NOP) [*8])
		else $error("command issued inside refresh cycle time");
	a_mode_load_idle: assert property (@(posedge clk) disable iff (!resetn)
		(s.cmd == CMD_LOAD_MODE) |=> (s.cmd == CMD_NOP) [*2])
		else $error("command issued inside mode load delay");
	a_powerup_cke_low: assert property (@(posedge clk) disable iff (!resetn)
		(s.state == DDRSEQ_POWERUP && s.wait_cnt > ONE) |-> !mem_cke)
		else $error("clock enable high during power-up wait");
	a_nop_first: assert property (@(posedge clk) disable iff (!resetn)
		$rose(mem_cke) |-> s.cmd == CMD_NOP ##1 s.cmd == CMD_NOP)
		else $error("no idle command after clock enable rose");
	a_ext_mode_word: assert property (@(posedge clk) disable iff (!resetn)
		(s.cmd == CMD_LOAD_MODE && s.ba == BA_EXT_MODE) |->
		s.addr[ADDR_W-1:EXT_DRIVE_STRENGTH_BIT+1] == '0 &&
		!s.addr[EXT_DLL_DISABLE_BIT])
		else $error("extended mode word has bad bits");
	a_dll_lock_wait: assert property (@(posedge clk) disable iff (!resetn)
		(s.cmd == CMD_LOAD_MODE && s.addr[MODE_DLL_RESET_BIT] &&
		s.ba == BA_BASE_MODE) |=> !s.dll_locked [*8])
		else $error("lock flag set too early after DLL reset");
	a_dll_lock_done: assert property (@(posedge clk) disable iff (!resetn)
		(s.cmd == CMD_LOAD_MODE && s.addr[MODE_DLL_RESET_BIT] &&
		s.ba == BA_BASE_MODE) |-> ##[1:DLL_WAIT_MAX] s.dll_locked)
		else $error("lock flag not set after DLL wait");
	a_refresh_gap: assert property (@(posedge clk) disable iff (!resetn)
		(s.done && rif.ctrl[CTRL_REFRESH_EN] && s.state == DDRSEQ_READY &&
		!rif.relock_pulse && s.gap_cnt <= RFC_CNT) |-> ##2 is_ref)
		else $error("refresh not issued when gap ran out");
	c_init_done: cover property (@(posedge clk) $rose(s.done));
	c_periodic_ref: cover property (@(posedge clk) s.done && is_ref);
	c_dll_clear: cover property (@(posedge clk)
		s.state == DDRSEQ_MR2_WAIT);
	c_relock: cover property (@(posedge clk) s.state == DDRSEQ_RELOCK);
endmodule
